// >>> logic/wdo_pkg.sv
/*
  wdo_pkg: option byte layout, stabilization codes and counts, carrier
  structs for the watchdog and oscillator option decoder.
  Assumes option bytes arrive as plain 8-bit words from the loader.
*/
package wdo_pkg;
  // ---------------------------------------------------------------
  // option byte layout
  // ---------------------------------------------------------------
  localparam int WDO_BYTE_W = 8;
  localparam int WDO_INDEP_WDOG_HW_START_BIT = 0;
  localparam int WDO_INDEP_WDOG_HALT_STOP_BIT = 1;
  localparam int WDO_WINDOW_WDOG_HW_START_BIT = 2;
  localparam int WDO_WINDOW_WDOG_HALT_RESET_BIT = 3;
  localparam int WDO_FAST_CNT_LSB = 0;
  localparam int WDO_SLOW_CNT_LSB = 2;
  localparam int WDO_CODE_W = 2;
  localparam logic [WDO_BYTE_W-1:0] WDO_OPT_RESET = 8'h00;

  // ---------------------------------------------------------------
  // stabilization counts
  // ---------------------------------------------------------------
  localparam int WDO_CNT_W = 13;
  localparam logic [WDO_CODE_W-1:0] WDO_CODE_1 = 2'h0;
  localparam logic [WDO_CODE_W-1:0] WDO_CODE_16 = 2'h1;
  localparam logic [WDO_CODE_W-1:0] WDO_CODE_512 = 2'h2;
  localparam logic [WDO_CODE_W-1:0] WDO_CODE_4096 = 2'h3;
  localparam logic [WDO_CNT_W-1:0] WDO_CYC_1 = 13'h0001;
  localparam logic [WDO_CNT_W-1:0] WDO_CYC_16 = 13'h0010;
  localparam logic [WDO_CNT_W-1:0] WDO_CYC_512 = 13'h0200;
  localparam logic [WDO_CNT_W-1:0] WDO_CYC_4096 = 13'h1000;
  localparam logic [WDO_CNT_W-1:0] WDO_CNT_ZERO = 13'h0000;
  localparam logic [WDO_CNT_W-1:0] WDO_CNT_ONE = 13'h0001;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic indep_wdog_hw_start;
    logic indep_wdog_halt_stop;
    logic window_wdog_hw_start;
    logic window_wdog_halt_reset;
  } wdo_wdog_cfg_t;

  typedef struct packed {
    logic indep_run;
    logic indep_freeze;
    logic window_run;
    logic window_halt_rst;
  } wdo_wdog_ctl_t;
endpackage

// >>> logic/wdo_settle.sv
/*
  wdo_settle: counts oscillator cycles after enable and raises ready once
  the configured stabilization count is reached.
  Assumes osc_tick is a one-cycle pulse per oscillator cycle in sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module wdo_settle
  import wdo_pkg::*;
#(
  parameter int CNT_W = WDO_CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic osc_enable,
  input wire logic osc_tick,
  input wire logic [WDO_CODE_W-1:0] settle_code,
  // status
  output logic osc_ready
);
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] target;
  logic ready_ff;

  always_comb begin
    case (settle_code)
      WDO_CODE_1: target = CNT_W'(WDO_CYC_1);
      WDO_CODE_16: target = CNT_W'(WDO_CYC_16);
      WDO_CODE_512: target = CNT_W'(WDO_CYC_512);
      WDO_CODE_4096: target = CNT_W'(WDO_CYC_4096);
      default: target = CNT_W'(WDO_CYC_4096);
    endcase
  end

  // ---------------------------------------------------------------
  // cycle count from zero on each enable
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_W'(WDO_CNT_ZERO);
    end else if (!osc_enable) begin
      count_ff <= CNT_W'(WDO_CNT_ZERO);
    end else if (osc_tick && count_ff < target) begin
      count_ff <= count_ff + CNT_W'(WDO_CNT_ONE);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_ff <= 1'h0;
    end else begin
      ready_ff <= osc_enable && (count_ff >= target);
    end
  end

  assign osc_ready = ready_ff;
endmodule
`default_nettype wire

// >>> logic/wdo_decode.sv
/*
  wdo_decode: captures the watchdog and oscillator option bytes after
  reset, derives watchdog start/halt controls and oscillator ready flags.
  Assumes option bytes are valid when opt_valid pulses, all inputs
  synchronous to sys_clk, and software start requests are pulses.
*/
// How it works
// - independent watchdog option 1 starts it at load; 0 waits for software.
// - independent halt option 0 keeps counting in halt; 1 freezes it.
// - window watchdog option 1 starts it at load; 0 waits for software.
// - window halt option 1 resets on halt entry; 0 just stops it.
// - fast oscillator code selects 1, 16, 512 or 4096 settle cycles.
// - slow oscillator code selects 1, 16, 512 or 4096 settle cycles.
`timescale 1ns/100ps
`default_nettype none
module wdo_decode
  import wdo_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // option bytes from nonvolatile memory
  input wire logic opt_valid,
  input wire logic [WDO_BYTE_W-1:0] watchdog_option_byte,
  input wire logic [WDO_BYTE_W-1:0] oscillator_option_byte,
  // software and power state
  input wire logic indep_sw_start,
  input wire logic window_sw_start,
  input wire logic cpu_halt,
  // oscillator side
  input wire logic fast_osc_enable,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_enable,
  input wire logic slow_osc_tick,
  // watchdog controls
  output logic loaded,
  output logic indep_wdog_run,
  output logic indep_wdog_freeze,
  output logic window_wdog_run,
  output logic window_wdog_halt_rst,
  // oscillator status
  output logic [WDO_CODE_W-1:0] fast_ext_osc_settle_count,
  output logic [WDO_CODE_W-1:0] slow_ext_osc_settle_count,
  output logic fast_osc_ready,
  output logic slow_osc_ready
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic srst_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'h0;
      rst_s2_ff <= 1'h0;
    end else begin
      rst_s1_ff <= 1'h1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign srst_n = rst_s2_ff;

  // ---------------------------------------------------------------
  // option capture
  // ---------------------------------------------------------------
  typedef enum logic {WDO_WAIT, WDO_LOADED} wdo_state_t;
  wdo_state_t state_ff;
  wdo_wdog_cfg_t cfg_ff;
  logic [WDO_BYTE_W-1:0] osc_opt_ff;

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff <= WDO_WAIT;
    end else begin
      case (state_ff)
        WDO_WAIT: if (opt_valid) state_ff <= WDO_LOADED;
        WDO_LOADED: state_ff <= WDO_LOADED;
        default: state_ff <= WDO_WAIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      cfg_ff <= '0;
      osc_opt_ff <= WDO_OPT_RESET;
    end else if (state_ff == WDO_WAIT && opt_valid) begin
      cfg_ff.indep_wdog_hw_start <= watchdog_option_byte[WDO_INDEP_WDOG_HW_START_BIT];
      cfg_ff.indep_wdog_halt_stop <= watchdog_option_byte[WDO_INDEP_WDOG_HALT_STOP_BIT];
      cfg_ff.window_wdog_hw_start <= watchdog_option_byte[WDO_WINDOW_WDOG_HW_START_BIT];
      cfg_ff.window_wdog_halt_reset <= watchdog_option_byte[WDO_WINDOW_WDOG_HALT_RESET_BIT];
      osc_opt_ff <= oscillator_option_byte;
    end
  end

  // ---------------------------------------------------------------
  // watchdog controls
  // ---------------------------------------------------------------
  logic loaded_ff;
  logic is_loaded;
  logic indep_start_now;
  logic window_start_now;
  logic indep_run_ff;
  logic indep_freeze_ff;
  logic window_started_ff;
  logic window_run_ff;
  logic window_halt_rst_ff;
  wdo_wdog_ctl_t ctl;

  // mirrors the capture edge so loaded comes from its own flop
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      loaded_ff <= 1'h0;
    end else if (state_ff == WDO_WAIT && opt_valid) begin
      loaded_ff <= 1'h1;
    end
  end
  assign is_loaded = loaded_ff;

  // start requests count only once the options are in
  assign indep_start_now = is_loaded
    && (cfg_ff.indep_wdog_hw_start || indep_sw_start);
  assign window_start_now = is_loaded
    && (cfg_ff.window_wdog_hw_start || window_sw_start);

  // once started the independent watchdog stays running until reset
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      indep_run_ff <= 1'h0;
    end else if (indep_start_now) begin
      indep_run_ff <= 1'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      indep_freeze_ff <= 1'h0;
    end else if (is_loaded) begin
      indep_freeze_ff <= cpu_halt && cfg_ff.indep_wdog_halt_stop;
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      window_started_ff <= 1'h0;
    end else if (window_start_now) begin
      window_started_ff <= 1'h1;
    end
  end

  // halt stops the window watchdog unless the option turns halt into a reset
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      window_run_ff <= 1'h0;
    end else begin
      window_run_ff <= (window_started_ff || window_start_now)
        && !(cpu_halt && !cfg_ff.window_wdog_halt_reset);
    end
  end

  // reset request only with an active window watchdog on halt
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      window_halt_rst_ff <= 1'h0;
    end else if (is_loaded) begin
      window_halt_rst_ff <= cpu_halt && cfg_ff.window_wdog_halt_reset
        && window_started_ff;
    end
  end

  // ---------------------------------------------------------------
  // watchdog outputs
  // ---------------------------------------------------------------
  assign ctl = {indep_run_ff, indep_freeze_ff, window_run_ff, window_halt_rst_ff};
  assign loaded = loaded_ff;
  assign indep_wdog_run = ctl.indep_run;
  assign indep_wdog_freeze = ctl.indep_freeze;
  assign window_wdog_run = ctl.window_run;
  assign window_wdog_halt_rst = ctl.window_halt_rst;

  // ---------------------------------------------------------------
  // oscillator settle
  // ---------------------------------------------------------------
  logic [WDO_CODE_W-1:0] fast_code;
  logic [WDO_CODE_W-1:0] slow_code;
  assign fast_code = osc_opt_ff[WDO_FAST_CNT_LSB +: WDO_CODE_W];
  assign slow_code = osc_opt_ff[WDO_SLOW_CNT_LSB +: WDO_CODE_W];
  assign fast_ext_osc_settle_count = fast_code;
  assign slow_ext_osc_settle_count = slow_code;

  localparam int OSC_N = 2;
  localparam int OSC_FAST = 0;
  localparam int OSC_SLOW = 1;
  logic [OSC_N-1:0] osc_enable_in;
  logic [OSC_N-1:0] osc_tick_in;
  logic [OSC_N-1:0][WDO_CODE_W-1:0] osc_code_in;
  logic [OSC_N-1:0] osc_ready_out;

  // fast oscillator in the low slot, slow one above it
  assign osc_enable_in = {slow_osc_enable, fast_osc_enable};
  assign osc_tick_in = {slow_osc_tick, fast_osc_tick};
  assign osc_code_in = {slow_code, fast_code};

  for (genvar g = 0; g < OSC_N; g++) begin : g_osc
    // counting waits for the options so the code is the captured one
    wdo_settle #(
      .CNT_W(WDO_CNT_W)
    ) u_settle (
      .sys_clk(sys_clk),
      .rst_n(srst_n),
      .osc_enable(osc_enable_in[g] && is_loaded),
      .osc_tick(osc_tick_in[g]),
      .settle_code(osc_code_in[g]),
      .osc_ready(osc_ready_out[g])
    );
  end

  assign fast_osc_ready = osc_ready_out[OSC_FAST];
  assign slow_osc_ready = osc_ready_out[OSC_SLOW];
endmodule
`default_nettype wire

// >>> sim/wdo_nvm_model.sv
/*
  wdo_nvm_model: option byte memory that hands its image over once per reset.
  Assumes the bench sets the images before releasing reset.
*/
`timescale 1ns/100ps
`default_nettype none
module wdo_nvm_model
  import wdo_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // stored images
  input wire logic [WDO_BYTE_W-1:0] wd_img,
  input wire logic [WDO_BYTE_W-1:0] osc_img,
  // load port
  output logic opt_valid,
  output logic [WDO_BYTE_W-1:0] watchdog_option_byte,
  output logic [WDO_BYTE_W-1:0] oscillator_option_byte
);
  // ---
  // one load pulse five edges after release
  // ---
  int n;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) n <= 0;
    else if (n < 6) n <= n + 1;
  end
  assign opt_valid = (n == 5);
  // bytes valid only with the pulse, inverted otherwise
  assign watchdog_option_byte = opt_valid ? wd_img : ~wd_img;
  assign oscillator_option_byte = opt_valid ? osc_img : ~osc_img;
endmodule
`default_nettype wire

// >>> sim/wdo_decode_checker.sv
/*
  wdo_decode_checker: timing relations at the decoder ports.
  Assumes binding into wdo_decode.
*/
`timescale 1ns/100ps
`default_nettype none
module wdo_decode_checker
  import wdo_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // requests into the decoder
  input wire logic indep_sw_start,
  input wire logic window_sw_start,
  input wire logic cpu_halt,
  input wire logic fast_osc_enable,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_enable,
  input wire logic slow_osc_tick,
  // decoder outputs
  input wire logic loaded,
  input wire logic indep_wdog_run,
  input wire logic indep_wdog_freeze,
  input wire logic window_wdog_run,
  input wire logic window_wdog_halt_rst,
  input wire logic fast_osc_ready,
  input wire logic slow_osc_ready,
  input wire logic [WDO_CODE_W-1:0] fast_ext_osc_settle_count,
  input wire logic [WDO_CODE_W-1:0] slow_ext_osc_settle_count
);
  // ---
  // tick counts since enable
  // ---
  logic [WDO_CNT_W-1:0] fc_ff, sc_ff;
  function automatic logic [WDO_CNT_W-1:0] tgt(input logic [WDO_CODE_W-1:0] c);
    return c == WDO_CODE_1 ? WDO_CYC_1 : c == WDO_CODE_16 ? WDO_CYC_16 :
      c == WDO_CODE_512 ? WDO_CYC_512 : WDO_CYC_4096;
  endfunction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n || !fast_osc_enable) fc_ff <= WDO_CNT_ZERO;
    else if (fast_osc_tick && fc_ff != WDO_CYC_4096) fc_ff <= fc_ff + WDO_CNT_ONE;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n || !slow_osc_enable) sc_ff <= WDO_CNT_ZERO;
    else if (slow_osc_tick && sc_ff != WDO_CYC_4096) sc_ff <= sc_ff + WDO_CNT_ONE;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_run_gated: assert property (!loaded |-> !indep_wdog_run && !window_wdog_run)
    else $error("watchdog ran before load");
  a_indep_sticky: assert property (indep_wdog_run |=> indep_wdog_run)
    else $error("independent watchdog stopped");
  a_indep_sw: assert property (loaded && indep_sw_start |=> indep_wdog_run)
    else $error("software start missed");
  a_window_sw: assert property (loaded && window_sw_start && !cpu_halt |=> window_wdog_run)
    else $error("window software start missed");
  a_freeze_cause: assert property (indep_wdog_freeze |-> $past(cpu_halt))
    else $error("freeze without halt");
  a_halt_rst_cause: assert property (window_wdog_halt_rst |-> $past(cpu_halt))
    else $error("halt reset without halt");
  a_window_halt: assert property (cpu_halt && window_wdog_run
    |=> window_wdog_halt_rst || !window_wdog_run)
    else $error("window kept running in halt");
  a_code_hold: assert property (loaded
    |=> $stable(fast_ext_osc_settle_count) && $stable(slow_ext_osc_settle_count))
    else $error("settle code changed");
  a_fast_ready: assert property (fast_osc_ready && fast_osc_enable
    |-> fc_ff >= tgt(fast_ext_osc_settle_count))
    else $error("fast ready early");
  a_slow_ready: assert property (slow_osc_ready && slow_osc_enable
    |-> sc_ff >= tgt(slow_ext_osc_settle_count))
    else $error("slow ready early");
  a_ready_drop: assert property (!fast_osc_enable [*2] |-> !fast_osc_ready)
    else $error("fast ready without enable");
endmodule
bind wdo_decode wdo_decode_checker i_wdo_decode_checker (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .indep_sw_start(indep_sw_start),
  .window_sw_start(window_sw_start),
  .cpu_halt(cpu_halt),
  .fast_osc_enable(fast_osc_enable),
  .fast_osc_tick(fast_osc_tick),
  .slow_osc_enable(slow_osc_enable),
  .slow_osc_tick(slow_osc_tick),
  .loaded(loaded),
  .indep_wdog_run(indep_wdog_run),
  .indep_wdog_freeze(indep_wdog_freeze),
  .window_wdog_run(window_wdog_run),
  .window_wdog_halt_rst(window_wdog_halt_rst),
  .fast_osc_ready(fast_osc_ready),
  .slow_osc_ready(slow_osc_ready),
  .fast_ext_osc_settle_count(fast_ext_osc_settle_count),
  .slow_ext_osc_settle_count(slow_ext_osc_settle_count)
);
`default_nettype wire

// >>> sim/test_wdo_decode.sv
/*
  test_wdo_decode: self-checking bench for wdo_decode with option memory model.
  Assumes a 20 MHz sys_clk and reset held for 3 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module test_wdo_decode
  import wdo_pkg::*;
;
  logic sys_clk = 1'h0, rst_n = 1'h0, indep_sw_start = 1'h0, window_sw_start = 1'h0;
  logic cpu_halt = 1'h0, fast_osc_enable = 1'h0, fast_osc_tick = 1'h0;
  logic slow_osc_enable = 1'h0, slow_osc_tick = 1'h0, opt_valid, loaded, indep_wdog_run;
  logic indep_wdog_freeze, window_wdog_run, window_wdog_halt_rst, fast_osc_ready, slow_osc_ready;
  logic [1:0] fast_ext_osc_settle_count, slow_ext_osc_settle_count;
  logic [7:0] watchdog_option_byte, oscillator_option_byte, wd_img = 8'h00, osc_img = 8'h00;
  logic [3:0] wdt [4] = '{4'h0, 4'hf, 4'h5, 4'ha};
  int bad_count = 0, n_checks = 0, fc, sc, i, k;
  logic ef, es;
  wdo_nvm_model i_wdo_nvm_model (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wd_img(wd_img),
    .osc_img(osc_img),
    .opt_valid(opt_valid),
    .watchdog_option_byte(watchdog_option_byte),
    .oscillator_option_byte(oscillator_option_byte)
  );
  wdo_decode i_wdo_decode (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .opt_valid(opt_valid),
    .watchdog_option_byte(watchdog_option_byte),
    .oscillator_option_byte(oscillator_option_byte),
    .indep_sw_start(indep_sw_start),
    .window_sw_start(window_sw_start),
    .cpu_halt(cpu_halt),
    .fast_osc_enable(fast_osc_enable),
    .fast_osc_tick(fast_osc_tick),
    .slow_osc_enable(slow_osc_enable),
    .slow_osc_tick(slow_osc_tick),
    .loaded(loaded),
    .indep_wdog_run(indep_wdog_run),
    .indep_wdog_freeze(indep_wdog_freeze),
    .window_wdog_run(window_wdog_run),
    .window_wdog_halt_rst(window_wdog_halt_rst),
    .fast_ext_osc_settle_count(fast_ext_osc_settle_count),
    .slow_ext_osc_settle_count(slow_ext_osc_settle_count),
    .fast_osc_ready(fast_osc_ready),
    .slow_osc_ready(slow_osc_ready)
  );
  always #25 sys_clk = ~sys_clk;
  // ---
  // helpers and verdict
  // ---
  task tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function int tgt(input int c);
    return c == 0 ? 1 : c == 1 ? 16 : c == 2 ? 512 : 4096;
  endfunction
  task chk(input string nm, input logic [12:0] e, input logic [12:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tk(60000);
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(24));
    for (i = 0; i < 4; i++) begin
      rst_n <= 1'h0;
      wd_img <= {4'($urandom), wdt[i]};
      osc_img <= {4'($urandom), 2'(3 - i), 2'(i)};
      tk(3);
      rst_n <= 1'h1;
      tk(1);
      #1 chk("reset run", 13'h0000, {loaded, indep_wdog_run, window_wdog_run});
      chk("reset ready", 13'h0000, {fast_osc_ready, slow_osc_ready});
      for (k = 0; k < 40 && loaded !== 1'h1; k++) begin tk(1); #1; end
      chk("loaded", 13'h0001, 13'(loaded));
      tk(1);
      #1 chk("hw run", {wd_img[2], wd_img[0]}, {window_wdog_run, indep_wdog_run});
      chk("codes", 13'(osc_img[3:0]),
        13'({slow_ext_osc_settle_count, fast_ext_osc_settle_count}));
      tk(1);
      indep_sw_start <= 1'h1;
      window_sw_start <= 1'h1;
      tk(1);
      indep_sw_start <= 1'h0;
      window_sw_start <= 1'h0;
      cpu_halt <= 1'h1;
      tk(2);
      #1 chk("halt", {wd_img[3], wd_img[1], 1'h0},
        {window_wdog_halt_rst, indep_wdog_freeze, window_wdog_run && !wd_img[3]});
      tk(1);
      cpu_halt <= 1'h0;
      tk(2);
      #1 chk("resume", 3'h6,
        {indep_wdog_run, window_wdog_run, indep_wdog_freeze | window_wdog_halt_rst});
      tk(1);
      fast_osc_enable <= 1'h1;
      slow_osc_enable <= 1'h1;
      fc = 0;
      sc = 0;
      for (k = 0; k < 20000 && (fc <= tgt(i) || sc <= tgt(3 - i)); k++) begin
        tk(1);
        ef = fc >= tgt(i);
        es = sc >= tgt(3 - i);
        fc += int'(fast_osc_tick);
        sc += int'(slow_osc_tick);
        fast_osc_tick <= 1'($urandom);
        slow_osc_tick <= 1'($urandom);
        #1 chk("fast ready", 13'(ef), 13'(fast_osc_ready));
        chk("slow ready", 13'(es), 13'(slow_osc_ready));
      end
      chk("settle limit", 13'h0001, 13'(fc > tgt(i) && sc > tgt(3 - i)));
      tk(1);
      fast_osc_enable <= 1'h0;
      slow_osc_enable <= 1'h0;
      tk(2);
      #1 chk("osc off", 13'h0000, {fast_osc_ready, slow_osc_ready});
      $display("test %0d done", i);
      tk(1);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
